//--- logic/abas_sequencer.sv
// The APB slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none

// Contract
// - burst runs only with burst select set; else one conversion per start.
// - burst wakes, takes 1/4/8/16 accumulated samples, returns to low power.
// - burst finishes on its own clock regardless of core clock speed; here it runs on clk_sys.
// - burst with power keep clear powers down after each burst.
// - burst with power keep set stays enabled, idling or tracking.
// - start while off in burst powers up and waits delay; else tracks at once, or converts at once with normal-mode pre tracking.
// - in burst one start runs repeat-count back-to-back conversions.
// - in normal mode each conversion needs its own start.
// - done flag set only when repeat-count samples are accumulated.
// - window compare waits for the full accumulation.
// - repeat one gives a 12-bit code, updated each conversion.
// - left justify bit picks 0x0FFF or 0xFFF0 placement.
// - unused result bits read zero.
// - repeat above one writes the sum after the last conversion.
// - series of 4, 8 or 16 samples, full scale 0x3FFC/0x7FF8/0xFFF0.
// - repeat count comes from the config register field.
// - conversion is 13 sar clocks plus 2 subsystem clocks.
// - hardware tracking is track time field plus 2 clocks.
// - subsystem clock is core clock or burst oscillator by burst select; here it is clk_sys in both settings.
// - end of the last conversion of a series sets done and raises enabled interrupt request.
module abas_sequencer import abas_pkg::*; (
	// clock and reset
	input wire logic clk_sys,
	input wire logic arst_n,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// convert start sources
	input wire logic tmr1Ovf,
	input wire logic tmr2Ovf,
	input wire logic externalConvertStart,
	// analog core
	input wire logic [11:0] sarCode,
	output logic adcPowerOn,
	output logic trackEn,
	output logic sarRun,
	output logic doneIrq
);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [4:0] rptSamples(input logic [1:0] code);
		case (code)
			RPT_4: rptSamples = 5'h04;
			RPT_8: rptSamples = 5'h08;
			RPT_16: rptSamples = 5'h10;
			default: rptSamples = 5'h01;
		endcase
	endfunction

	function automatic logic [7:0] convCycles(input logic [2:0] div);
		convCycles = 8'(CONV_SAR_CYC * (int'(div) + 1) + CONV_EXTRA_CYC);
	endfunction

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	abas_ctrl_s ctrl_q, ctrl_d;
	abas_cfg_s cfg_q;
	abas_state_e state_q, state_d;
	logic [15:0] gt_q, lt_q, result_q, result_d;
	logic [15:0] acc_q, acc_d;
	logic [4:0] nSamp_q, nSamp_d;
	logic [7:0] cnt_q, cnt_d;
	logic pwrOn_q, pwrOn_d;
	logic [31:0] prdata_q;
	logic pready_q, pslverr_q, trackEn_q, sarRun_q, doneIrq_q;
	logic extSync1_q, extSync2_q, extPrev_q;

	// ----------------------------------------------------------------
	// apb decode
	// ----------------------------------------------------------------
	wire apbAcc = psel & penable & ~pready_q;
	wire apbDone = psel & penable & pready_q;
	wire wrDone = apbDone & pwrite;
	wire hitCtrl = paddr == ADDR_CTRL;
	wire hitCfg = paddr == ADDR_CFG;
	wire hitRes = paddr == ADDR_RESULT;
	wire hitGt = paddr == ADDR_GT;
	wire hitLt = paddr == ADDR_LT;
	wire mapped = hitCtrl | hitCfg | hitRes | hitGt | hitLt;
	wire wrCtrl = wrDone & hitCtrl;
	wire idle = state_q == ST_IDLE;
	wire [31:0] rdMux = hitCtrl ? {23'h0, ctrl_q[8:1], ~idle} :
		hitCfg ? {16'h0, cfg_q} :
		hitRes ? {16'h0, result_q} :
		hitGt ? {16'h0, gt_q} :
		hitLt ? {16'h0, lt_q} : 32'h0;

	// ----------------------------------------------------------------
	// convert start selection
	// ----------------------------------------------------------------
	// pin is asynchronous: two flops before the edge detector
	wire extRise = extSync2_q & ~extPrev_q;
	wire swStart = wrCtrl & pwdata[CTRL_BUSY_BIT];
	wire startReq = ctrl_q.startSrc == SRC_SW ? swStart :
		ctrl_q.startSrc == SRC_EXT ? extRise :
		ctrl_q.startSrc == SRC_TMR1 ? tmr1Ovf : tmr2Ovf;
	// subsystem clock is clk_sys in both settings: one domain only
	wire burst = ctrl_q.burstSelect;
	// normal mode needs the converter enabled; starts while running drop
	wire startTake = startReq & idle & (burst | ctrl_q.powerKeep);
	wire preTrack = ~burst & (cfg_q.trackMode == TM_PRE);
	wire convEnd = (state_q == ST_CONV) & (cnt_q == 8'h00);
	wire [4:0] nextCount = 5'(nSamp_q + 5'h01);
	wire seriesDone = convEnd & (nextCount == rptSamples(cfg_q.repeatCount));
	wire [15:0] sampleSum = 16'(acc_q + {4'h0, sarCode});
	wire single = cfg_q.repeatCount == RPT_1;
	wire [15:0] fmtCode = ctrl_q.leftJustify ? {sarCode, 4'h0} :
		{4'h0, sarCode};
	// accumulated sums are always right justified
	wire [15:0] newResult = single ? fmtCode : sampleSum;
	wire winHit = (newResult > gt_q) & (newResult < lt_q);
	wire [7:0] trackLoad = 8'({4'h0, cfg_q.trackTime} + 8'(TRACK_EXTRA_CYC - 1));
	wire [7:0] pwrLoad = 8'(({3'h0, cfg_q.powerUpDelay} + 8'h01) * 8'(PWRUP_UNIT_CYC) - 8'h01);
	wire [7:0] convLoad = 8'(convCycles(cfg_q.sarDiv) - 8'h01);

	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		cnt_d = (cnt_q == 8'h00) ? 8'h00 : 8'(cnt_q - 8'h01);
		pwrOn_d = burst ? pwrOn_q | ctrl_q.powerKeep : ctrl_q.powerKeep;
		acc_d = acc_q;
		nSamp_d = nSamp_q;
		result_d = result_q;
		case (state_q)
			ST_IDLE: begin
				if (startTake && burst && !pwrOn_q) begin
					state_d = ST_PWRUP;
					cnt_d = pwrLoad;
					pwrOn_d = 1'b1;
				end else if (startTake && preTrack) begin
					state_d = ST_CONV;
					cnt_d = convLoad;
				end else if (startTake) begin
					state_d = ST_TRACK;
					cnt_d = trackLoad;
				end
			end
			ST_PWRUP: begin
				if (cnt_q == 8'h00) begin
					state_d = ST_TRACK;
					cnt_d = trackLoad;
				end
			end
			ST_TRACK: begin
				if (cnt_q == 8'h00) begin
					state_d = ST_CONV;
					cnt_d = convLoad;
				end
			end
			ST_CONV: begin
				if (cnt_q == 8'h00) begin
					acc_d = seriesDone ? 16'h0000 : sampleSum;
					nSamp_d = seriesDone ? 5'h00 : nextCount;
					if (seriesDone) begin
						result_d = newResult;
					end
					if (burst && !seriesDone) begin
						state_d = ST_TRACK;
						cnt_d = trackLoad;
					end else begin
						state_d = ST_IDLE;
					end
					if (burst && seriesDone && !ctrl_q.powerKeep) begin
						pwrOn_d = 1'b0;
					end
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// control register: hardware set wins over software clear
	// ----------------------------------------------------------------
	always_comb begin
		ctrl_d = ctrl_q;
		if (wrCtrl) begin
			ctrl_d = abas_ctrl_s'(pwdata[8:0]);
			ctrl_d.doneFlag = ctrl_q.doneFlag & pwdata[1];
			ctrl_d.winFlag = ctrl_q.winFlag & pwdata[7];
		end
		ctrl_d.busy = 1'b0;
		if (seriesDone) begin
			ctrl_d.doneFlag = 1'b1;
		end
		if (seriesDone && winHit) begin
			ctrl_d.winFlag = 1'b1;
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			state_q <= ST_IDLE;
			cnt_q <= 8'h00;
			pwrOn_q <= 1'b0;
			acc_q <= 16'h0000;
			nSamp_q <= 5'h00;
			result_q <= RESULT_RST;
			ctrl_q <= CTRL_RST;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			pwrOn_q <= pwrOn_d;
			acc_q <= acc_d;
			nSamp_q <= nSamp_d;
			result_q <= result_d;
			ctrl_q <= ctrl_d;
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			cfg_q <= CFG_RST;
			gt_q <= GT_RST;
			lt_q <= LT_RST;
		end else begin
			if (wrDone && hitCfg) cfg_q <= abas_cfg_s'(pwdata[15:0]);
			if (wrDone && hitGt) gt_q <= pwdata[15:0];
			if (wrDone && hitLt) lt_q <= pwdata[15:0];
		end
	end

	// ----------------------------------------------------------------
	// bus answer, pin synchroniser and analog controls
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			prdata_q <= 32'h0;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			extSync1_q <= 1'b0;
			extSync2_q <= 1'b0;
			extPrev_q <= 1'b0;
			trackEn_q <= 1'b0;
			sarRun_q <= 1'b0;
			doneIrq_q <= 1'b0;
		end else begin
			prdata_q <= (apbAcc && !pwrite) ? rdMux : 32'h0;
			pready_q <= apbAcc;
			pslverr_q <= apbAcc & ~mapped;
			extSync1_q <= externalConvertStart;
			extSync2_q <= extSync1_q;
			extPrev_q <= extSync2_q;
			// dual and pre tracking keep the input connected when idle
			trackEn_q <= state_d == ST_TRACK || (state_d == ST_PWRUP
				&& cfg_q.trackMode == TM_DUAL) || (state_d == ST_IDLE
				&& pwrOn_d && cfg_q.trackMode[1]);
			sarRun_q <= state_d == ST_CONV;
			doneIrq_q <= ctrl_d.doneFlag & ctrl_d.irqEn;
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign adcPowerOn = pwrOn_q;
	assign trackEn = trackEn_q;
	assign sarRun = sarRun_q;
	assign doneIrq = doneIrq_q;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	logic [7:0] trkLen_q, cnvLen_q;
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			trkLen_q <= 8'h00;
			cnvLen_q <= 8'h00;
		end else begin
			trkLen_q <= state_q == ST_TRACK ? 8'(trkLen_q + 8'h01) : 8'h00;
			cnvLen_q <= state_q == ST_CONV ? 8'(cnvLen_q + 8'h01) : 8'h00;
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!arst_n);

	property p_trackLen;
		state_q == ST_TRACK && state_d != ST_TRACK |->
			8'(trkLen_q + 8'h01) == 8'({4'h0, cfg_q.trackTime} + 8'h02);
	endproperty
	a_trackLen: assert property (p_trackLen) else $error("track length wrong");

	property p_convLen;
		convEnd |-> 8'(cnvLen_q + 8'h01) == convCycles(cfg_q.sarDiv);
	endproperty
	a_convLen: assert property (p_convLen) else $error("conversion length wrong");

	property p_doneCause;
		$rose(ctrl_q.doneFlag) |-> $past(seriesDone);
	endproperty
	a_doneCause: assert property (p_doneCause) else $error("done without series end");

	property p_resultHold;
		!$stable(result_q) |-> $past(seriesDone);
	endproperty
	a_resultHold: assert property (p_resultHold) else $error("result changed mid series");

	property p_justify;
		seriesDone && single |=>
			(ctrl_q.leftJustify ? result_q[3:0] : result_q[15:12]) == 4'h0;
	endproperty
	a_justify: assert property (p_justify) else $error("unused result bits set");

	property p_powerDown;
		seriesDone && burst && !ctrl_q.powerKeep |=>
			!pwrOn_q && state_q == ST_IDLE;
	endproperty
	a_powerDown: assert property (p_powerDown) else $error("no power down");

	property p_wake;
		startTake && burst && !pwrOn_q |=> state_q == ST_PWRUP && pwrOn_q;
	endproperty
	a_wake: assert property (p_wake) else $error("no power-up on start");

	property p_burstRun;
		burst && convEnd && !seriesDone |=> state_q == ST_TRACK;
	endproperty
	a_burstRun: assert property (p_burstRun) else $error("burst stopped early");

	property p_normalStop;
		!burst && convEnd |=> state_q == ST_IDLE;
	endproperty
	a_normalStop: assert property (p_normalStop) else $error("normal mode ran on");

	property p_ignoreStart;
		!idle && state_q != ST_CONV && cnt_q != 8'h00 && startReq |=>
			state_q == $past(state_q) && nSamp_q == $past(nSamp_q);
	endproperty
	a_ignoreStart: assert property (p_ignoreStart) else $error("start restarted series");

	property p_winWait;
		$rose(ctrl_q.winFlag) |-> $past(seriesDone);
	endproperty
	a_winWait: assert property (p_winWait) else $error("early window compare");

	c_burst16: cover property (burst && seriesDone && cfg_q.repeatCount == RPT_16);
	c_powerUp: cover property (state_q == ST_PWRUP ##[1:300] state_q == ST_TRACK);
	c_normalAcc: cover property (!burst && seriesDone && !single);
	c_window: cover property ($rose(ctrl_q.winFlag));

endmodule // abas_sequencer
`default_nettype wire

//--- pkg/abas_pkg.sv
`default_nettype none
package abas_pkg;

	// ----------------------------------------------------------------
	// register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_CFG = 8'h04;
	localparam logic [7:0] ADDR_RESULT = 8'h08;
	localparam logic [7:0] ADDR_GT = 8'h0C;
	localparam logic [7:0] ADDR_LT = 8'h10;

	// ----------------------------------------------------------------
	// field layouts
	// ----------------------------------------------------------------
	// control: bit0 busy, 1 done, 2 left justify, 3 burst select,
	// 4 power keep, 6:5 start source, 7 window hit, 8 irq enable
	typedef struct packed {
		logic irqEn;
		logic winFlag;
		logic [1:0] startSrc;
		logic powerKeep;
		logic burstSelect;
		logic leftJustify;
		logic doneFlag;
		logic busy;
	} abas_ctrl_s;

	// config: 1:0 repeat, 3:2 tracking mode, 7:4 track time,
	// 12:8 power-up delay, 15:13 sar clock divider
	typedef struct packed {
		logic [2:0] sarDiv;
		logic [4:0] powerUpDelay;
		logic [3:0] trackTime;
		logic [1:0] trackMode;
		logic [1:0] repeatCount;
	} abas_cfg_s;

	localparam int CTRL_BUSY_BIT = 0;
	localparam abas_ctrl_s CTRL_RST = 9'h000;
	localparam abas_cfg_s CFG_RST = 16'h0004;
	localparam logic [15:0] GT_RST = 16'hFFFF;
	localparam logic [15:0] LT_RST = 16'h0000;
	localparam logic [15:0] RESULT_RST = 16'h0000;

	// ----------------------------------------------------------------
	// encodings
	// ----------------------------------------------------------------
	localparam logic [1:0] SRC_SW = 2'h0;
	localparam logic [1:0] SRC_EXT = 2'h1;
	localparam logic [1:0] SRC_TMR1 = 2'h2;
	localparam logic [1:0] SRC_TMR2 = 2'h3;
	localparam logic [1:0] TM_POST = 2'h1;
	localparam logic [1:0] TM_PRE = 2'h2;
	localparam logic [1:0] TM_DUAL = 2'h3;
	localparam logic [1:0] RPT_1 = 2'h0;
	localparam logic [1:0] RPT_4 = 2'h1;
	localparam logic [1:0] RPT_8 = 2'h2;
	localparam logic [1:0] RPT_16 = 2'h3;

	// ----------------------------------------------------------------
	// timing, in subsystem clock cycles
	// ----------------------------------------------------------------
	localparam int TRACK_EXTRA_CYC = 2;
	localparam int CONV_SAR_CYC = 13;
	localparam int CONV_EXTRA_CYC = 2;
	localparam int PWRUP_UNIT_CYC = 8;

	typedef enum logic [1:0] {ST_IDLE, ST_PWRUP, ST_TRACK, ST_CONV} abas_state_e;

endpackage
`default_nettype wire

//--- verif/abas_analog_model.sv
`timescale 1ns/1ns
`default_nettype none
// ------------------------------
// analog core stand-in
// ------------------------------
module abas_analog_model (
	// converter status and input level
	input wire logic sarRun,
	input wire logic [11:0] level,
	// code out
	output logic [11:0] sarCode
);
	// inverted outside conversion so a stale sample cannot pass
	assign sarCode = sarRun ? level : ~level;
endmodule // abas_analog_model
`default_nettype wire

//--- verif/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top import abas_pkg::*;;
	logic clk_sys, arst_n, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic tmr1Ovf, tmr2Ovf, extStart, adcPowerOn, trackEn, sarRun, doneIrq;
	logic [11:0] level, sarCode;
	int fails, num_checks, nOff, nTrk1, nTrk, nSar, nRun;
	logic [7:0] regA [5];
	logic [31:0] regV [5];

	abas_sequencer uut (.clk_sys(clk_sys), .arst_n(arst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .tmr1Ovf(tmr1Ovf), .tmr2Ovf(tmr2Ovf),
		.externalConvertStart(extStart), .sarCode(sarCode),
		.adcPowerOn(adcPowerOn), .trackEn(trackEn), .sarRun(sarRun),
		.doneIrq(doneIrq));
	abas_analog_model model (.sarRun(sarRun), .level(level),
		.sarCode(sarCode));

	// ------------------------------
	// helpers
	// ------------------------------
	task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	task final_report;
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_sys);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20)
			chk(0, 1, "no pready");
	endtask

	// irq enable always set so doneIrq marks the end of a series
	function logic [31:0] ctl(input logic [1:0] src, input logic pk,
		input logic bs, input logic lj, input logic go);
		ctl = {23'h0, 1'b1, 1'b0, src, pk, bs, lj, 1'b0, go};
	endfunction

	task meas;
		int n;
		logic ps;
		n = 0;
		ps = 1'b0;
		nOff = 0;
		nTrk1 = 0;
		nTrk = 0;
		nSar = 0;
		nRun = 0;
		do begin
			@(posedge clk_sys);
			#1;
			n++;
			if (trackEn === 1'b1 && nTrk1 == 0)
				nTrk1 = n;
			nTrk += (trackEn === 1'b1);
			nSar += (sarRun === 1'b1);
			nRun += (sarRun === 1'b1 && ps !== 1'b1);
			ps = sarRun;
			if (adcPowerOn === 1'b0 && nOff == 0 && n > 1)
				nOff = n;
		end while (!(doneIrq === 1'b1 && n > 2) && n < 3000);
		if (n >= 3000)
			chk(0, 1, "no done");
	endtask

	// ------------------------------
	// stimulus
	// ------------------------------
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	initial begin
		#400000;
		fails++;
		final_report();
	end

	initial begin
		{arst_n, psel, penable, pwrite, tmr1Ovf, tmr2Ovf, extStart} = 7'h00;
		paddr = 8'h00;
		pwdata = 32'h0;
		level = 12'h000;
		fails = 0;
		num_checks = 0;
		regA = '{ADDR_CTRL, ADDR_CFG, ADDR_RESULT, ADDR_GT, ADDR_LT};
		regV = '{32'h0, 32'h4, 32'h0, 32'hFFFF, 32'h0};
		repeat (4) @(posedge clk_sys);
		arst_n <= 1'b1;
		for (int i = 0; i < 5; i++) begin
			apb(1'b0, regA[i], 32'h0);
			chk(rd, regV[i], "reset value");
		end
		apb(1'b0, 8'h14, 32'h0);
		chk({rd[30:0], err}, 32'h1, "unmapped");
		apb(1'b1, ADDR_RESULT, 32'hFFFF);
		apb(1'b0, ADDR_RESULT, 32'h0);
		chk(rd, 32'h0, "result read-only");
		// mode bits first: a start is decoded with the mode already held
		apb(1'b1, ADDR_CTRL, ctl(SRC_SW, 1'b0, 1'b1, 1'b0, 1'b0));
		// burst from powered down, both justifications
		for (int i = 0; i < 2; i++) begin
			level <= i ? 12'hFFF : 12'hABC;
			apb(1'b1, ADDR_CFG, {28'h0, TM_POST, RPT_1});
			apb(1'b1, ADDR_CTRL, ctl(SRC_SW, 1'b0, 1'b1, i[0], 1'b1));
			meas();
			chk(nTrk1, 8, "power-up delay");
			chk(nTrk, 2, "track length");
			chk(nSar, 15, "convert length");
			chk(nOff, 25, "power down");
			apb(1'b0, ADDR_RESULT, 32'h0);
			chk(rd, i ? 32'hFFF0 : 32'hABC, "justify");
			apb(1'b0, ADDR_CTRL, 32'h0);
			chk(rd[1], 1'b1, "done flag");
		end
		// accumulation, with a second start while busy
		level <= 12'hFFF;
		for (int r = 1; r < 4; r++) begin
			apb(1'b1, ADDR_CFG, {28'h0, (r == 2) ? TM_DUAL : TM_POST,
				r[1:0]});
			apb(1'b1, ADDR_CTRL, ctl(SRC_SW, 1'b0, 1'b1, 1'b0, 1'b1));
			// five clocks between starts
			@(posedge clk_sys);
			apb(1'b1, ADDR_CTRL, ctl(SRC_SW, 1'b0, 1'b1, 1'b0, 1'b1));
			meas();
			chk(nRun, 2 << r, "series length");
			chk(nSar, 15 << (r + 1), "back to back");
			apb(1'b0, ADDR_RESULT, 32'h0);
			chk(rd, 32'hFFF << (r + 1), "sum");
		end
		// power kept between bursts: second start tracks at once
		apb(1'b1, ADDR_CFG, {28'h0, TM_POST, RPT_1});
		for (int k = 0; k < 2; k++) begin
			apb(1'b1, ADDR_CTRL, ctl(SRC_SW, 1'b1, 1'b1, 1'b0, 1'b1));
			meas();
		end
		chk(nTrk1, 1, "no power-up");
		chk(nOff, 0, "stays powered");
		chk(adcPowerOn, 1'b1, "power kept");
		// pin start, held well beyond the minimum spacing
		level <= 12'h123;
		apb(1'b1, ADDR_CTRL, ctl(SRC_EXT, 1'b1, 1'b1, 1'b0, 1'b0));
		@(posedge clk_sys);
		extStart <= 1'b1;
		meas();
		extStart <= 1'b0;
		apb(1'b0, ADDR_RESULT, 32'h0);
		chk(rd, 32'h123, "pin start");
		// normal mode: one start per conversion, window after the sum
		level <= 12'h0AA;
		apb(1'b1, ADDR_GT, 32'h80);
		for (int s = 0; s < 2; s++) begin
			// second pass converts at once from pre tracking
			apb(1'b1, ADDR_CFG, {28'h0, s ? TM_PRE : TM_POST, RPT_4});
			apb(1'b1, ADDR_LT, s ? 32'h400 : 32'h200);
			apb(1'b1, ADDR_CTRL, ctl(s ? SRC_TMR2 : SRC_TMR1, 1'b1, 1'b0,
				1'b0, 1'b0));
			for (int j = 0; j < 4; j++) begin
				@(posedge clk_sys);
				{tmr2Ovf, tmr1Ovf} <= s ? 2'b10 : 2'b01;
				@(posedge clk_sys);
				{tmr2Ovf, tmr1Ovf} <= 2'b00;
				repeat (40) @(posedge clk_sys);
				if (j == 2) begin
					apb(1'b0, ADDR_CTRL, 32'h0);
					chk(rd[1], 1'b0, "early done");
				end
			end
			apb(1'b0, ADDR_CTRL, 32'h0);
			chk({rd[7], rd[1]}, {s[0], 1'b1}, "window");
			apb(1'b0, ADDR_RESULT, 32'h0);
			chk(rd, 32'h2A8, "normal sum");
		end
		final_report();
	end
endmodule // tb_top
`default_nettype wire
